/* File: inc/port_c_defs.svh */
// register offsets, reset values and pin positions for the third i/o port
`ifndef PORT_C_DEFS_SVH
`define PORT_C_DEFS_SVH
`define PC_ADDR_W 4
`define PC_OFS_PIN_LEVEL 4'h0
`define PC_OFS_OUT_LATCH 4'h1
`define PC_OFS_DIRECTION 4'h2
`define PC_OFS_PERIPH_CTRL 4'h3
`define PC_OFS_PERIPH_STAT 4'h4
`define PC_DIR_RESET 8'hff
`define PC_LATCH_RESET 8'h00
`define PC_CTRL_RESET 8'h01
`define PC_CTRL_PINSEL_BIT 0
`define PC_CTRL_OSC_EN_BIT 1
`define PC_CTRL_CCP_EN_BIT 2
`define PC_CTRL_CCP_OUT_BIT 3
`define PC_PIN_OSC_OUT 0
`define PC_PIN_SECOND 1
`endif

/* File: inc/port_c_pkg.sv */
// types shared by the third i/o port
package port_c_pkg;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

/* File: src/port_c_gpio.sv */
// third i/o port: direction, output latch, pin levels and peripheral takeover
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "port_c_defs.svh"
module port_c_gpio
  import port_c_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire reg_req_t req,
  output logic [7:0] rdata,
  // pins, already schmitt-conditioned by the pad
  input wire logic [7:0] pin_in,
  output pin_drive_t pin_drv,
  // second compare unit, pin one routing
  input wire logic ccp_out_level,
  output logic ccp_capture_in,
  output logic ccp_on_other_port,
  // timer oscillator pads see analog pins while enabled
  output logic timer_osc_active
);
  // stored register bits
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic pinsel_q;
  logic pinsel_d;
  logic osc_en_q;
  logic osc_en_d;
  logic unit_en_q;
  logic unit_en_d;
  logic unit_mode_q;
  logic unit_mode_d;
  logic [7:0] pin_level_q;

  // register port decode
  logic wr_pin_level;
  logic wr_latch;
  logic wr_dir;
  logic wr_ctrl;

  // peripheral claims on the pins
  logic ccp_pin_out;
  logic ccp_pin_in;
  logic [7:0] osc_claim;
  logic [7:0] ccp_claim;

  // next values of the registered outputs
  logic [7:0] drv_out_d;
  logic [7:0] drv_oe_d;
  logic [7:0] rdata_d;
  logic [7:0] ctrl_word;
  logic [7:0] stat_word;
  logic [7:0] pin_read_word;
  logic ccp_capture_d;
  logic ccp_other_d;
  logic osc_active_d;

  // reset image of the control byte, split into its fields below
  localparam logic [7:0] ctrl_reset = `PC_CTRL_RESET;

  // one strobe per register except the read-only status one; the pin level address is a second door to the latch,
  // so software that writes the port rather than the latch still sets the outputs;
  // the bus never waits, so every strobe is taken on the edge that sees it
  assign wr_pin_level = req.wr && (req.addr == `PC_OFS_PIN_LEVEL);
  assign wr_latch = req.wr && (req.addr == `PC_OFS_OUT_LATCH);
  assign wr_dir = req.wr && (req.addr == `PC_OFS_DIRECTION);
  assign wr_ctrl = req.wr && (req.addr == `PC_OFS_PERIPH_CTRL);

  // latch next value: either address writes the same bits, so clears agree
  always_comb begin
    latch_d = latch_q;
    if (wr_pin_level || wr_latch) begin
      latch_d = req.wdata;
    end
  end

  // output latch; its own address reads these bits, not the pin levels,
  // so read-modify-write never picks up a level forced by the outside
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= `PC_LATCH_RESET;
    end else begin
      latch_q <= latch_d;
    end
  end

  // direction next value; only software writes it, peripherals never do
  always_comb begin
    dir_d = dir_q;
    if (wr_dir) begin
      dir_d = req.wdata;
    end
  end

  // direction bits; all ones after reset leaves every pin an input
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_q <= `PC_DIR_RESET;
    end else begin
      dir_q <= dir_d;
    end
  end

  // control next values, taken apart from the written byte;
  // bits 7:4 have no storage and read back as zero
  always_comb begin
    pinsel_d = pinsel_q;
    osc_en_d = osc_en_q;
    unit_en_d = unit_en_q;
    unit_mode_d = unit_mode_q;
    if (wr_ctrl) begin
      pinsel_d = req.wdata[`PC_CTRL_PINSEL_BIT];
      osc_en_d = req.wdata[`PC_CTRL_OSC_EN_BIT];
      unit_en_d = req.wdata[`PC_CTRL_CCP_EN_BIT];
      unit_mode_d = req.wdata[`PC_CTRL_CCP_OUT_BIT];
    end
  end

  // pin select; one after reset keeps the compare unit on pin one,
  // zero hands it to the other port and frees pin one for plain i/o
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinsel_q <= ctrl_reset[`PC_CTRL_PINSEL_BIT];
    end else begin
      pinsel_q <= pinsel_d;
    end
  end

  // timer oscillator enable; the pads do the analog work, we only release them
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_en_q <= ctrl_reset[`PC_CTRL_OSC_EN_BIT];
    end else begin
      osc_en_q <= osc_en_d;
    end
  end

  // compare unit enable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      unit_en_q <= ctrl_reset[`PC_CTRL_CCP_EN_BIT];
    end else begin
      unit_en_q <= unit_en_d;
    end
  end

  // compare unit mode: one drives pin one, zero captures from it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      unit_mode_q <= ctrl_reset[`PC_CTRL_CCP_OUT_BIT];
    end else begin
      unit_mode_q <= unit_mode_d;
    end
  end

  // pin sampling; the pad's schmitt buffer cleans the level, we only register it;
  // a level reaches read data two edges after it settles on the pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_level_q <= 8'h00;
    end else begin
      pin_level_q <= pin_in;
    end
  end

  // the compare unit claims pin one only while routed here and enabled
  assign ccp_pin_out = pinsel_q & unit_en_q & unit_mode_q;
  assign ccp_pin_in = pinsel_q & unit_en_q & ~unit_mode_q;

  // per-pin drive: direction bit first, then the unit claim, the oscillator last;
  // the claim only overrides the drive, never the stored direction bits, so
  // software finds its own setting again once the peripheral lets go
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic oe_b;
      logic out_b;
      // claim masks; only pins zero and one ever see a peripheral
      assign osc_claim[g] = osc_en_q && (g == `PC_PIN_OSC_OUT || g == `PC_PIN_SECOND);
      assign ccp_claim[g] = (g == `PC_PIN_SECOND) && (ccp_pin_out || ccp_pin_in);
      // oscillator beats the unit: both pins are analog while it runs
      always_comb begin
        oe_b = ~dir_q[g];
        out_b = latch_q[g];
        if (ccp_claim[g]) begin
          oe_b = ccp_pin_out;
          if (ccp_pin_out) begin
            out_b = ccp_out_level;
          end
        end
        if (osc_claim[g]) begin
          oe_b = 1'b0;
          out_b = 1'b0;
        end
      end
      assign drv_oe_d[g] = oe_b;
      assign drv_out_d[g] = out_b;
    end
  endgenerate

  // registered pin values so outputs never glitch on control writes;
  // the price is one edge between a write and the pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_drv.out <= 8'h00;
    end else begin
      pin_drv.out <= drv_out_d;
    end
  end

  // registered pin enables; all off in reset, so every pin starts as an input
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_drv.oe <= 8'h00;
    end else begin
      pin_drv.oe <= drv_oe_d;
    end
  end

  // words as software sees them; unused bits read zero
  assign ctrl_word = {4'h0, unit_mode_q, unit_en_q, osc_en_q, pinsel_q};
  assign stat_word = {6'h00, ccp_pin_out, osc_en_q};
  // oscillator pins are analog, so their digital reads show zero
  assign pin_read_word = pin_level_q & ~osc_claim;

  // read mux; no read strobe gives zero, so stale data never lingers on the bus
  always_comb begin
    rdata_d = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `PC_OFS_PIN_LEVEL: rdata_d = pin_read_word;
        `PC_OFS_OUT_LATCH: rdata_d = latch_q;
        `PC_OFS_DIRECTION: rdata_d = dir_q;
        `PC_OFS_PERIPH_CTRL: rdata_d = ctrl_word;
        `PC_OFS_PERIPH_STAT: rdata_d = stat_word;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // read data, one cycle after the strobe and only there;
  // unmapped addresses are not an error, they simply read zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_d;
    end
  end

  // peripheral side next values; a moved unit sees no capture from this port
  assign ccp_capture_d = pinsel_q & pin_level_q[`PC_PIN_SECOND];
  assign ccp_other_d = ~pinsel_q;
  assign osc_active_d = osc_en_q;

  // capture level routed to the unit; it still follows the pad while the
  // oscillator runs, so the unit must not capture then
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ccp_capture_in <= 1'b0;
    end else begin
      ccp_capture_in <= ccp_capture_d;
    end
  end

  // routing flag for the other port
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ccp_on_other_port <= 1'b0;
    end else begin
      ccp_on_other_port <= ccp_other_d;
    end
  end

  // oscillator active flag for the pads
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_osc_active <= 1'b0;
    end else begin
      timer_osc_active <= osc_active_d;
    end
  end
endmodule

/* File: verif/port_c_gpio_checker.sv */
// assertions on the third i/o port
`timescale 1ns/1ps
module port_c_gpio_checker
  import port_c_pkg::*;
(
  // watched ports
  input wire logic core_clk,
  input wire logic rst_b,
  input wire reg_req_t req,
  input wire logic [7:0] rdata,
  input wire pin_drive_t pin_drv,
  input wire logic ccp_capture_in,
  input wire logic ccp_on_other_port,
  input wire logic timer_osc_active
);
  logic [7:0] lat_q, dir_q;
  logic [3:0] ctl_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // shadow registers, so pin checks do not trust the reads
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) {lat_q, dir_q, ctl_q} <= 20'h00ff1;
    else if (req.wr && req.addr < 4'h2) lat_q <= req.wdata;
    else if (req.wr && req.addr == 4'h2) dir_q <= req.wdata;
    else if (req.wr && req.addr == 4'h3) ctl_q <= req.wdata[3:0];
  chk_reset_in: assert property ($rose(rst_b) |-> !pin_drv.oe)
    else $error("pins driven after reset");
  chk_dir_oe: assert property (pin_drv.oe[7:2] == ~$past(dir_q[7:2]))
    else $error("enable differs from direction");
  chk_lat_out: assert property (!((pin_drv.out ^ $past(lat_q)) & pin_drv.oe & 8'hfc))
    else $error("pin differs from latch");
  chk_osc_pins: assert property (timer_osc_active [*2] |-> !pin_drv.oe[1:0])
    else $error("oscillator pins driven");
  chk_ccp_pin: assert property ($past(ctl_q[2:0] == 3'h5) |-> pin_drv.oe[1] == $past(ctl_q[3]))
    else $error("unit override wrong");
  chk_other_port: assert property (ccp_on_other_port |-> !ccp_capture_in)
    else $error("capture seen on moved unit");
  chk_dir_read: assert property (req.rd && req.addr == 4'h2 |=> rdata == dir_q)
    else $error("direction read wrong");
  chk_lat_read: assert property (req.rd && req.addr == 4'h1 |=> rdata == lat_q)
    else $error("latch read wrong");
  cover property (timer_osc_active [*2]);
  cover property (ccp_on_other_port);
  cover property (req.rd ##1 req.rd);
endmodule

/* File: verif/port_c_pins.sv */
// outside circuitry: pin wires with an external driver
`timescale 1ns/1ps
module port_c_pins
  import port_c_pkg::*;
(
  // device drive, outside level, wire level
  input wire pin_drive_t drv,
  input wire logic [7:0] ext,
  output logic [7:0] lvl
);
  // device wins where it drives, else the outside level
  assign lvl = (drv.out & drv.oe) | (ext & ~drv.oe);
endmodule

/* File: verif/port_c_gpio_tb.sv */
// bench for the third i/o port
`timescale 1ns/1ps
module port_c_gpio_tb;
  import port_c_pkg::*;
  logic core_clk = 0, rst_b = 0, cl = 1;
  reg_req_t req = '0;
  logic [7:0] rdata, pin_in;
  pin_drive_t pin_drv;
  logic oth, cin, osc;
  int n_mismatch = 0, n_tests = 0;
  port_c_gpio i_dut (.core_clk(core_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .pin_in(pin_in), .pin_drv(pin_drv), .ccp_out_level(cl), .ccp_capture_in(cin),
    .ccp_on_other_port(oth), .timer_osc_active(osc));
  port_c_pins i_pins (.drv(pin_drv), .ext(8'ha5), .lvl(pin_in));
  // clock and watchdog
  initial forever #12.5 core_clk = ~core_clk;
  initial begin
    #20us n_mismatch++;
    finish_test();
  end
  task chk(input string n, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) req.wr <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) req.rd <= 0;
    #1 chk("rdata", rdata, e);
  endtask
  task t_io;
    wr(4'h0, 8'h58);
    wr(4'h2, 8'h0f);
    rd(4'h1, 8'h58);
    rd(4'h9, 8'h00);
    chk("pins", pin_in, 8'h55);
    rd(4'h0, 8'h55);
  endtask
  task t_periph;
    wr(4'h3, 8'h0d);
    rd(4'h4, 8'h02);
    chk("pins", pin_in, 8'h57);
    rd(4'h0, 8'h57);
    chk("capture", {7'h00, cin}, 8'h01);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h05);
    rd(4'h2, 8'h00);
    chk("oe", pin_drv.oe, 8'hfd);
    wr(4'h3, 8'h03);
    rd(4'h4, 8'h01);
    chk("osc", {7'h00, osc}, 8'h01);
    chk("oe", pin_drv.oe, 8'hfc);
    wr(4'h3, 8'h00);
    rd(4'h3, 8'h00);
    chk("moved", {7'h00, oth}, 8'h01);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1;
    rd(4'h2, 8'hff);
    chk("oe", pin_drv.oe, 8'h00);
    t_io();
    t_periph();
    finish_test();
  end
  task finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
endmodule
bind port_c_gpio port_c_gpio_checker i_chk (.*);
